// ### rtl/schb_map.svh
// Constants of the sealing control bit handler: timing, limits, error codes, APB register offsets.
`ifndef SCHB_MAP_SVH
`define SCHB_MAP_SVH
`define SCHB_CLK_HZ        40000000
`define SCHB_POWERUP_S     10
`define SCHB_INIT_MS       500
`define SCHB_CAL_MIN_S     10
`define SCHB_BLINK_HZ      4
`define SCHB_CAL_TEMP_MAX  10'd40
`define SCHB_HEAT_MARGIN   10'd20
`define SCHB_RANGE_LO_MAX  10'd300
`define SCHB_RANGE_HI_MAX  10'd500
`define SCHB_CAL_RETRIES   2'd3
`define SCHB_ERR_TOO_HOT   10'd115
`define SCHB_ERR_FLUCT     10'd116
`define SCHB_ERR_CAL_FAIL  10'd117
`define SCHB_ZERO_OUT      16'h0000
// APB register byte offsets.
`define SCHB_OFF_CTRL      12'h000
`define SCHB_OFF_STATUS    12'h004
`define SCHB_OFF_ACTUAL    12'h008
`define SCHB_OFF_ERROR     12'h00c
`define SCHB_OFF_SETPT     12'h010
`define SCHB_OFF_DRIFT     12'h014
`define SCHB_OFF_CONFIG    12'h018
`endif

// ### rtl/schb_pkg.sv
// Types shared by the sealing control bit handler.
package schb_pkg;
   typedef enum logic [1:0] {schb_idle_s, schb_wait_s, schb_cal_s} schb_cal_state_type;

   // Control word bits from the fieldbus master.
   typedef struct packed {
      logic [2:0] set_sel;
      logic       reference_calibrate;
      logic       measure_hold;
      logic       clear_fault_request;
      logic       heat_request;
      logic       autozero_request;
   } schb_ctrl_type;

   // Measurement-side inputs from the element front end.
   typedef struct packed {
      logic [15:0] actual;
      logic        cooling_fast;
      logic        temp_fluct;
      logic        cal_done;
      logic        cal_fail;
      logic [31:0] resistance;
      logic        system_ok;
      logic        alarm;
      logic [9:0]  err_no;
   } schb_meas_type;
endpackage

// ### rtl/schb_top.sv
// Sealing control bit handler: control word interpreter with APB registers.
`timescale 1ns/1ps
`default_nettype none
`include "schb_map.svh"

// What this block does
// - With variable cal temperature, take setpoint 0..40 C at each zero calibration.
// - Raise error 115 if cal temperature over 40 C, 116 if it fluctuates.
// - Calibration runs about 10 to 15 seconds with no heating.
// - During calibration assert cal_running, light indicator, force actual output to zero.
// - On fluctuation retry calibration at most twice (three attempts in all), then report error.
// - Refuse calibration for 10 s after power-on, asserting cal_inhibited.
// - Defer calibration while cooling faster than 0.1 K/s, start once slower.
// - No calibration while heat_request or clear_fault_request; flash calibration indicator.
// - Block calibration on early or severe errors depending on prior good operation.
// - Flash calibration indicator at 4 Hz when inhibited and requested.
// - Ignore heat_request on cal, alarm, clear_fault or low setpoint; flash heat LED.
// - Heat request during warning errors switches alarm output on, starts no new heating.
// - clear_fault_request rejects requests, stops power and impulses, keeps running cal.
// - While clear_fault_request, force actual output to zero and assert hold_ack.
// - After clear_fault_request release, run 500 ms initialisation before sealing.
// - measure_hold stops impulses and holds actual value; other requests have priority.
// - Clearing measure_hold resumes at once; setting it never clears alarms.
// - Ignore measure_hold until the power-on system check passes.
// - reference_calibrate runs calibration and stores resistance as drift reference.
// - Three bits select one of eight sets; calibration keeps its starting set.
// - Clamp setpoint to 300 C or 500 C by temperature range.
// - Without cyclic data treat control bits except set_sel as zero, keep running sealing.
// - Assert hold_ack while clear_fault or measure_hold is accepted.
module schb_top #(
   parameter int unsigned POWERUP_CYC = `SCHB_POWERUP_S * `SCHB_CLK_HZ,
   parameter int unsigned INIT_CYC    = (`SCHB_INIT_MS * (`SCHB_CLK_HZ / 1000)),
   parameter int unsigned CAL_CYC     = `SCHB_CAL_MIN_S * `SCHB_CLK_HZ,
   parameter int unsigned BLINK_CYC   = `SCHB_CLK_HZ / (2 * `SCHB_BLINK_HZ)
) (
   // Clock and reset.
   input  wire logic                  pclk,
   input  wire logic                  presetn,
   // APB slave.
   input  wire logic                  psel,
   input  wire logic                  penable,
   input  wire logic                  pwrite,
   input  wire logic [11:0]           paddr,
   input  wire logic [31:0]           pwdata,
   output logic      [31:0]           prdata,
   output logic                       pready,
   output logic                       pslverr,
   // Element front end, same clock.
   input  wire schb_pkg::schb_meas_type meas,
   // Device outputs.
   output logic                       heat_enable,
   output logic                       impulse_enable,
   output logic                       alarm_out,
   output logic                       cal_led,
   output logic                       heat_led,
   output logic [15:0]                actual_out
);
   import schb_pkg::*;

   // =====================================================================
   // State.
   typedef struct packed {
      schb_ctrl_type      ctrl;
      logic               cyc_valid;
      logic [9:0]         setpt;
      logic               var_cal_temp;
      logic               range_hi;
      logic [9:0]         cal_temp;
      schb_cal_state_type cst;
      logic               cal_is_ref;
      logic [2:0]         cal_set;
      logic [2:0]         act_set;
      logic [1:0]         tries;
      logic [31:0]        cal_cnt;
      logic [31:0]        pwr_cnt;
      logic [31:0]        init_cnt;
      logic [31:0]        blink_cnt;
      logic               blink;
      logic               sys_ok;
      logic               good_once;
      logic               rf_d;
      logic               heating;
      logic               warn_alarm;
      logic [9:0]         cal_err;
      logic [31:0]        ref_res;
      logic [31:0]        drift;
      logic [15:0]        held;
      logic [31:0]        prdata;
      logic               pready;
      logic               pslverr;
      logic               heat_led;
      logic               cal_led;
      logic [15:0]        actual;
      logic               heat_en;
      logic               imp_en;
      logic               alarm;
   } schb_state_type;

   schb_state_type s_r, s_nxt;

   // =====================================================================
   // Error classes.
   function automatic logic in_rng(input logic [9:0] e, input logic [9:0] lo, input logic [9:0] hi);
      return (e >= lo) && (e <= hi);
   endfunction

   logic       pwr_block, hard_err, early_err, warn_err, hold_ok, cal_block;
   logic       cal_req, heat_ok, rf_hold, meas_hold;
   logic [9:0] clamp_sp;
   logic       wr, rd;

   always_comb begin
      hard_err  = in_rng(meas.err_no, 10'd201, 10'd203) || in_rng(meas.err_no, 10'd900, 10'd999);
      early_err = in_rng(meas.err_no, 10'd101, 10'd103);
      warn_err  = in_rng(meas.err_no, 10'd104, 10'd106) || in_rng(meas.err_no, 10'd111, 10'd114)
                  || meas.err_no == 10'd211 || meas.err_no == 10'd302 || meas.err_no == 10'd303;
   end

   // Request decoding; missing cyclic data reads as all-zero control bits.
   always_comb begin
      pwr_block = s_r.pwr_cnt != 32'd0;
      cal_req   = s_r.cyc_valid && (s_r.ctrl.autozero_request || s_r.ctrl.reference_calibrate);
      rf_hold   = s_r.cyc_valid && s_r.ctrl.clear_fault_request;
      meas_hold = s_r.cyc_valid && s_r.ctrl.measure_hold && s_r.sys_ok && !rf_hold
                  && !s_r.ctrl.heat_request && s_r.cst == schb_idle_s;
      cal_block = pwr_block || (s_r.cyc_valid && s_r.ctrl.heat_request) || rf_hold
                  || hard_err || (!s_r.good_once && early_err);
      clamp_sp  = s_r.range_hi ? ((s_r.setpt > `SCHB_RANGE_HI_MAX) ? `SCHB_RANGE_HI_MAX : s_r.setpt)
                               : ((s_r.setpt > `SCHB_RANGE_LO_MAX) ? `SCHB_RANGE_LO_MAX : s_r.setpt);
      heat_ok   = s_r.cst == schb_idle_s && !meas.alarm && !rf_hold && s_r.init_cnt == 32'd0
                  && clamp_sp > s_r.cal_temp + `SCHB_HEAT_MARGIN;
      hold_ok   = rf_hold || meas_hold;
      wr        = psel && penable && pwrite;
      rd        = psel && !penable && !pwrite;
   end

   // =====================================================================
   // Next state.
   always_comb begin
      s_nxt = s_r;
      s_nxt.pready  = psel && !penable;
      s_nxt.pslverr = 1'b0;
      // Register writes take effect in the access phase.
      if (wr) begin
         case (paddr)
            `SCHB_OFF_CTRL: begin
               s_nxt.ctrl      = pwdata[7:0];
               s_nxt.cyc_valid = pwdata[8];
            end
            `SCHB_OFF_SETPT:  s_nxt.setpt = pwdata[9:0];
            `SCHB_OFF_CONFIG: begin
               s_nxt.var_cal_temp = pwdata[0];
               s_nxt.range_hi     = pwdata[1];
            end
            default: s_nxt.pslverr = 1'b0;
         endcase
      end
      if (rd) begin
         case (paddr)
            `SCHB_OFF_CTRL:   s_nxt.prdata = {23'h0, s_r.cyc_valid, s_r.ctrl};
            // Status: bit0 cal_running, 1 cal_inhibited, 2 hold_ack, 5:3 active set.
            `SCHB_OFF_STATUS: s_nxt.prdata = {26'h0, s_r.act_set, hold_ok,
                                              cal_block, s_r.cst == schb_cal_s};
            `SCHB_OFF_ACTUAL: s_nxt.prdata = {16'h0, s_r.actual};
            `SCHB_OFF_ERROR:  s_nxt.prdata = {22'h0, s_r.cal_err};
            `SCHB_OFF_SETPT:  s_nxt.prdata = {22'h0, clamp_sp};
            `SCHB_OFF_DRIFT:  s_nxt.prdata = s_r.drift;
            `SCHB_OFF_CONFIG: s_nxt.prdata = {30'h0, s_r.range_hi, s_r.var_cal_temp};
            default:          s_nxt.prdata = 32'h0;
         endcase
      end
      if (s_r.pwr_cnt != 32'd0) s_nxt.pwr_cnt = s_r.pwr_cnt - 32'd1;
      if (meas.system_ok) s_nxt.sys_ok = 1'b1;
      s_nxt.rf_d = rf_hold;
      if (rf_hold) s_nxt.init_cnt = INIT_CYC;
      else if (s_r.init_cnt != 32'd0) s_nxt.init_cnt = s_r.init_cnt - 32'd1;
      if (s_r.blink_cnt == 32'd0) begin
         s_nxt.blink_cnt = BLINK_CYC - 1;
         s_nxt.blink     = !s_r.blink;
      end else begin
         s_nxt.blink_cnt = s_r.blink_cnt - 32'd1;
      end
      // Calibration sequencer.
      case (s_r.cst)
         schb_idle_s: if (cal_req && !cal_block) begin
            s_nxt.cst        = schb_wait_s;
            s_nxt.cal_is_ref = s_r.ctrl.reference_calibrate;
            s_nxt.tries      = 2'd0;
            s_nxt.cal_set    = s_r.ctrl.set_sel;
            s_nxt.act_set    = s_r.ctrl.set_sel;
            if (s_r.var_cal_temp) begin
               if (s_r.setpt > `SCHB_CAL_TEMP_MAX) begin
                  s_nxt.cst     = schb_idle_s;
                  s_nxt.cal_err = `SCHB_ERR_TOO_HOT;
               end else begin
                  s_nxt.cal_temp = s_r.setpt;
               end
            end
         end
         schb_wait_s: if (!cal_req || cal_block) begin
            s_nxt.cst = schb_idle_s;
         end else if (!meas.cooling_fast) begin
            s_nxt.cst     = schb_cal_s;
            s_nxt.cal_cnt = CAL_CYC;
            s_nxt.cal_err = 10'd0;
         end
         schb_cal_s: begin
            if (s_r.cal_cnt != 32'd0) s_nxt.cal_cnt = s_r.cal_cnt - 32'd1;
            if (s_r.var_cal_temp && s_r.setpt != s_r.cal_temp) begin
               s_nxt.cst     = schb_idle_s;
               s_nxt.cal_err = `SCHB_ERR_FLUCT;
            end else if (meas.temp_fluct || meas.cal_fail) begin
               if (s_r.tries == `SCHB_CAL_RETRIES - 2'd1) begin
                  s_nxt.cst     = schb_idle_s;
                  s_nxt.cal_err = `SCHB_ERR_CAL_FAIL;
               end else begin
                  s_nxt.tries   = s_r.tries + 2'd1;
                  s_nxt.cal_cnt = CAL_CYC;
               end
            end else if (meas.cal_done && s_r.cal_cnt == 32'd0) begin
               s_nxt.cst       = schb_idle_s;
               s_nxt.good_once = 1'b1;
               if (s_r.cal_is_ref) s_nxt.ref_res = meas.resistance;
               else s_nxt.drift = meas.resistance - s_r.ref_res;
            end
         end
         default: s_nxt.cst = schb_idle_s;
      endcase
      // the set in use stays latched from acceptance to the end of calibration.
      if (s_nxt.cst == schb_idle_s) s_nxt.act_set = s_r.ctrl.set_sel;
      else s_nxt.act_set = s_nxt.cal_set;
      // heating path; ignore missing data only for an ongoing seal.
      if (!s_r.heating)
         s_nxt.heating = s_r.cyc_valid && s_r.ctrl.heat_request && heat_ok && !warn_err;
      else if ((s_r.cyc_valid && !s_r.ctrl.heat_request) || meas.alarm || rf_hold)
         s_nxt.heating = 1'b0;
      // a clean heating cycle counts as correct operation; a set flag is never cleared.
      if (s_r.heating && !meas.alarm) s_nxt.good_once = 1'b1;
      s_nxt.warn_alarm = warn_err && s_r.cyc_valid && s_r.ctrl.heat_request;
      s_nxt.heat_led = s_r.heating
                       || (s_r.cyc_valid && s_r.ctrl.heat_request && !heat_ok && s_r.blink);
      s_nxt.cal_led = (s_r.cst == schb_cal_s) || (cal_req && cal_block && s_r.blink);
      if (s_r.cst == schb_cal_s || rf_hold) s_nxt.actual = `SCHB_ZERO_OUT;
      else if (meas_hold) s_nxt.actual = s_r.held;
      else begin
         s_nxt.actual = meas.actual;
         s_nxt.held   = meas.actual;
      end
      // power and impulses; the relay also trips for a warning with a heat request.
      s_nxt.heat_en = s_nxt.heating && s_nxt.cst == schb_idle_s;
      s_nxt.imp_en  = !rf_hold && !meas_hold;
      s_nxt.alarm   = (meas.alarm && !warn_err) || s_nxt.warn_alarm;
   end

   // State register.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s_r          <= '0;
         s_r.pwr_cnt  <= POWERUP_CYC;
         s_r.cal_temp <= 10'd20;
      end else begin
         s_r <= s_nxt;
      end
   end

   // Outputs come straight from the state register.
   assign heat_enable    = s_r.heat_en;
   assign impulse_enable = s_r.imp_en;
   assign alarm_out      = s_r.alarm;
   assign prdata     = s_r.prdata;
   assign pready     = s_r.pready;
   assign pslverr    = s_r.pslverr;
   assign cal_led    = s_r.cal_led;
   assign heat_led   = s_r.heat_led;
   assign actual_out = s_r.actual;

   // =====================================================================
   // Assertions.
   property p_inhibit_powerup;
      @(posedge pclk) disable iff (!presetn) (s_r.pwr_cnt != 32'd0) |-> s_r.cst != schb_cal_s;
   endproperty
   a_inhibit_powerup: assert property (p_inhibit_powerup) else $error("cal during power-up");

   property p_zero_cal;
      @(posedge pclk) disable iff (!presetn) s_r.cst == schb_cal_s |=> actual_out == 16'h0;
   endproperty
   a_zero_cal: assert property (p_zero_cal) else $error("actual not zero in cal");

   property p_no_heat_cal;
      @(posedge pclk) disable iff (!presetn) s_nxt.cst == schb_cal_s |=> !heat_enable;
   endproperty
   a_no_heat_cal: assert property (p_no_heat_cal) else $error("heating during cal");

   property p_rf_zero;
      @(posedge pclk) disable iff (!presetn) rf_hold |=> actual_out == 16'h0 && !impulse_enable;
   endproperty
   a_rf_zero: assert property (p_rf_zero) else $error("clear fault output wrong");

   sequence s_rf_fall;
      s_r.rf_d && !rf_hold;
   endsequence
   property p_init_wait;
      @(posedge pclk) disable iff (!presetn) s_rf_fall |=> !heat_enable [*2];
   endproperty
   a_init_wait: assert property (p_init_wait) else $error("heat during init");

   property p_hold_value;
      @(posedge pclk) disable iff (!presetn)
         meas_hold && $stable(meas_hold) |=> $stable(actual_out);
   endproperty
   a_hold_value: assert property (p_hold_value) else $error("actual changed in hold");

   property p_set_locked;
      @(posedge pclk) disable iff (!presetn)
         s_r.cst == schb_cal_s && s_nxt.cst == schb_cal_s |=> $stable(s_r.act_set);
   endproperty
   a_set_locked: assert property (p_set_locked) else $error("set changed in cal");

   property p_too_hot;
      @(posedge pclk) disable iff (!presetn)
         s_r.cst == schb_idle_s && cal_req && !cal_block && s_r.var_cal_temp
         && s_r.setpt > 10'd40 |=> s_r.cal_err == 10'd115;
   endproperty
   a_too_hot: assert property (p_too_hot) else $error("error 115 missing");

   // A warning with a fresh heat request must trip the relay and keep the power off.
   sequence s_warn_heat;
      warn_err && s_r.cyc_valid && s_r.ctrl.heat_request && !s_r.heating;
   endsequence
   property p_warn_alarm;
      @(posedge pclk) disable iff (!presetn) s_warn_heat |=> alarm_out && !heat_enable;
   endproperty
   a_warn_alarm: assert property (p_warn_alarm) else $error("warning heat not refused");

   // An accepted hold stops the measurement impulses one cycle later.
   property p_hold_ack;
      @(posedge pclk) disable iff (!presetn) hold_ok |=> !impulse_enable;
   endproperty
   a_hold_ack: assert property (p_hold_ack) else $error("impulses during hold");

   // The calibration indicator is lit steadily while a calibration runs.
   property p_cal_led;
      @(posedge pclk) disable iff (!presetn) s_r.cst == schb_cal_s |=> cal_led;
   endproperty
   a_cal_led: assert property (p_cal_led) else $error("cal indicator dark in cal");

   // A setpoint too close to the calibration temperature never starts heating.
   property p_heat_low;
      @(posedge pclk) disable iff (!presetn)
         !s_r.heating && clamp_sp <= s_r.cal_temp + 10'd20 |=> !heat_enable;
   endproperty
   a_heat_low: assert property (p_heat_low) else $error("heat on low setpoint");
endmodule
`default_nettype wire

// ### test/schb_front_model.sv
// Element front-end model that feeds the measurement bundle of the handler.
`timescale 1ns/1ps
`default_nettype none
module schb_front_model #(
   parameter logic [31:0] ELEM_OHM = 32'h0000_1234
) (
   // Clock and reset.
   input  wire logic               pclk,
   input  wire logic               presetn,
   // Scenario controls from the bench.
   input  wire logic               cool,
   input  wire logic               done,
   input  wire logic [9:0]         err,
   // Measurement bundle.
   output var schb_pkg::schb_meas_type meas
);
   import schb_pkg::*;
   // ==========================================
   // Element temperature
   logic [15:0] temp_r;
   // The value moves every cycle, so a frozen actual output stands out.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         temp_r <= 16'h0100;
      end else begin
         temp_r <= temp_r + 16'h0003;
      end
   end
   // A healthy element; cooling, completion and error number follow the bench.
   // contactor closes in time, so the front end never raises an alarm.
   always_comb begin
      meas            = '0;
      meas.actual     = temp_r;
      meas.cooling_fast = cool;
      meas.cal_done   = done;
      meas.resistance = ELEM_OHM;
      meas.system_ok  = 1'b1;
      meas.err_no     = err;
   end
endmodule
`default_nettype wire

// ### test/tb_sealing_control_bit_handler.sv
// Self-checking bench of the sealing control bit handler.
`timescale 1ns/1ps
`default_nettype none
`include "schb_map.svh"
module tb_sealing_control_bit_handler;
   import schb_pkg::*;
   // ==========================================
   // Signals
   logic          pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic [11:0]   paddr;
   logic [31:0]   pwdata, prdata, rd;
   logic          heat_enable, impulse_enable, alarm_out, cal_led, heat_led;
   logic [15:0]   actual_out, held;
   logic          cool, done, led_q;
   logic [9:0]    v, err;
   logic [2:0]    sel, s0;
   schb_meas_type meas;
   int            fails, checks_done, seed, n, i;

   schb_top #(.POWERUP_CYC(20), .INIT_CYC(10), .CAL_CYC(15), .BLINK_CYC(4)) i_schb_top (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .meas(meas), .heat_enable(heat_enable), .impulse_enable(impulse_enable),
      .alarm_out(alarm_out), .cal_led(cal_led), .heat_led(heat_led), .actual_out(actual_out));
   schb_front_model i_schb_front_model (
      .pclk(pclk), .presetn(presetn), .cool(cool), .done(done), .err(err), .meas(meas));

   // ==========================================
   // Clock and watchdog
   initial begin
      pclk = 1'b0;
      forever #12.5 pclk = ~pclk;
   end
   // The sequence needs a few hundred cycles; this limit leaves ample margin.
   initial begin
      repeat (20000) @(posedge pclk);
      fails++;
      end_sim();
   end

   // ==========================================
   // Tasks and functions
   task automatic cyc(input int k);
      repeat (k) @(posedge pclk);
   endtask
   // One APB transfer, held until pready is seen at a rising edge.
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      // Only the watchdog ends a wait for the answer.
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      rd = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   // Reads a register until the masked value appears, with a bounded count.
   task automatic poll(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
      int t;
      t = 0;
      do begin
         apb(1'b0, a, 32'h0);
         t++;
      end while ((rd & m) !== e && t < 60);
   endtask
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      checks_done++;
      if (g !== e) begin
         fails++;
         $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic end_sim;
      $display("checks %0d mismatches %0d", checks_done, fails);
      if (fails == 0 && checks_done > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   // Control word with cyclic data valid and the current set selection.
   function automatic logic [31:0] ctl(input logic [4:0] b);
      return {23'h0, 1'b1, sel, b};
   endfunction
   function automatic logic [31:0] exp_sp(input logic [9:0] x, input logic hi);
      logic [9:0] lim;
      lim = hi ? `SCHB_RANGE_HI_MAX : `SCHB_RANGE_LO_MAX;
      return {22'h0, (x > lim) ? lim : x};
   endfunction

   // ==========================================
   // Main sequence
   initial begin
      {psel, penable, pwrite, paddr, pwdata, cool, done, err} = '0;
      presetn = 1'b0;
      seed = 32'h0040;
      fails = 0;
      checks_done = 0;
      sel = 3'($random(seed));
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      cool <= 1'b1;
      @(posedge pclk);
      // Early request is refused and the indicator flashes.
      apb(1'b1, `SCHB_OFF_CTRL, ctl(5'h01));
      apb(1'b0, `SCHB_OFF_STATUS, 32'h0);
      chk("inhibit", 32'h2, rd & 32'h3);
      n = 0;
      led_q = cal_led;
      for (i = 0; i < 10; i++) begin
         @(posedge pclk);
         if (cal_led !== led_q) n++;
         led_q = cal_led;
      end
      chk("cal_flash", 32'h1, 32'(n > 0));
      cyc(30);
      apb(1'b0, `SCHB_OFF_STATUS, 32'h0);
      chk("cool_defer", 32'h0, rd & 32'h1);
      cool <= 1'b0;
      poll(`SCHB_OFF_STATUS, 32'h1, 32'h1);
      chk("cal_start", 32'h1, rd & 32'h1);
      chk("set_used", 32'(sel), 32'(rd[5:3]));
      chk("actual_cal", 32'h0, 32'(actual_out));
      chk("heat_cal", 32'h0, 32'(heat_enable));
      s0 = sel;
      sel = sel + 3'h1;
      apb(1'b1, `SCHB_OFF_CTRL, ctl(5'h00));
      apb(1'b0, `SCHB_OFF_STATUS, 32'h0);
      chk("set_kept", 32'(s0), 32'(rd[5:3]));
      done <= 1'b1;
      poll(`SCHB_OFF_STATUS, 32'h1, 32'h0);
      chk("cal_end", 32'h0, rd & 32'h1);
      done <= 1'b0;
      chk("set_new", 32'(sel), 32'(rd[5:3]));
      // Setpoint clamp in both ranges, boundary and random values.
      for (i = 0; i < 12; i++) begin
         v = (i % 3 == 0) ? 10'h3ff : 10'($random(seed));
         apb(1'b1, `SCHB_OFF_CONFIG, {30'h0, i >= 6, 1'b0});
         apb(1'b1, `SCHB_OFF_SETPT, {22'h0, v});
         apb(1'b0, `SCHB_OFF_SETPT, 32'h0);
         chk("sp_clamp", exp_sp(v, i >= 6), rd);
      end
      // Heat needs the setpoint above calibration temperature plus margin.
      apb(1'b1, `SCHB_OFF_CONFIG, 32'h0);
      apb(1'b1, `SCHB_OFF_SETPT, 32'd40);
      apb(1'b1, `SCHB_OFF_CTRL, ctl(5'h02));
      cyc(8);
      chk("heat_low", 32'h0, 32'(heat_enable));
      apb(1'b1, `SCHB_OFF_SETPT, 32'd200);
      for (n = 0; n < 40 && heat_enable !== 1'b1; n++) cyc(1);
      chk("heat_on", 32'h1, 32'(heat_enable));
      cyc(1);
      chk("heat_led", 32'h1, 32'(heat_led));
      apb(1'b1, `SCHB_OFF_CTRL, ctl(5'h00));
      cyc(3);
      chk("heat_off", 32'h0, 32'(heat_enable));
      // Fault clear with heat pending, then release into initialisation.
      apb(1'b1, `SCHB_OFF_CTRL, ctl(5'h06));
      cyc(3);
      apb(1'b0, `SCHB_OFF_STATUS, 32'h0);
      chk("ack_clear", 32'h1, 32'(rd[2]));
      chk("actual_clr", 32'h0, 32'(actual_out));
      chk("power_clr", 32'h0, 32'({heat_enable, impulse_enable}));
      apb(1'b1, `SCHB_OFF_CTRL, ctl(5'h02));
      chk("init_heat", 32'h0, 32'(heat_enable));
      for (n = 0; n < 60 && heat_enable !== 1'b1; n++) cyc(1);
      chk("heat_after", 32'h1, 32'(heat_enable));
      chk("init_len", 32'h1, 32'(n >= 10));
      apb(1'b1, `SCHB_OFF_CTRL, ctl(5'h00));
      // Without cyclic data the fault-clear bit acts as zero.
      apb(1'b1, `SCHB_OFF_CTRL, 32'h0000_0004);
      cyc(3);
      apb(1'b0, `SCHB_OFF_STATUS, 32'h0);
      chk("no_cyclic", 32'h0, 32'(rd[2]));
      // Measurement hold freezes the value and stops impulses.
      apb(1'b1, `SCHB_OFF_CTRL, ctl(5'h08));
      cyc(3);
      held = actual_out;
      cyc(5);
      chk("hold_val", 32'(held), 32'(actual_out));
      chk("hold_imp", 32'h0, 32'(impulse_enable));
      apb(1'b0, `SCHB_OFF_STATUS, 32'h0);
      chk("ack_hold", 32'h1, 32'(rd[2]));
      apb(1'b1, `SCHB_OFF_CTRL, ctl(5'h00));
      cyc(3);
      chk("resume_imp", 32'h1, 32'(impulse_enable));
      held = actual_out;
      cyc(2);
      chk("resume_val", 32'h1, 32'(actual_out !== held));
      // Unmapped place reads zero and never errors.
      apb(1'b1, 12'h0f0, 32'hffff_ffff);
      apb(1'b0, 12'h0f0, 32'h0);
      chk("unmapped", 32'h0, rd);
      chk("slverr", 32'h0, 32'(pslverr));
      // A warning error with a heat request trips the alarm relay and keeps power off.
      err <= 10'd104;
      apb(1'b1, `SCHB_OFF_CTRL, ctl(5'h02));
      cyc(3);
      chk("warn_alarm", 32'h1, 32'(alarm_out));
      chk("warn_heat", 32'h0, 32'(heat_enable));
      apb(1'b1, `SCHB_OFF_CTRL, ctl(5'h00));
      err <= 10'd0;
      // Variable calibration temperature above the limit.
      apb(1'b1, `SCHB_OFF_CONFIG, 32'h1);
      // setpoint stays fixed through the request
      apb(1'b1, `SCHB_OFF_SETPT, 32'd45);
      apb(1'b1, `SCHB_OFF_CTRL, ctl(5'h01));
      poll(`SCHB_OFF_ERROR, 32'h3ff, 32'd115);
      chk("err_hot", 32'd115, rd & 32'h3ff);
      end_sim();
   end
endmodule
`default_nettype wire
